// *** verilog/flash_ctrl_pkg.sv ***
// Operation
// [R1] Enable pin low: shutdown, bus port disabled, all configuration back to defaults.
// [R2] In shutdown every bus transaction is ignored and never answered.
// [R3] Enable pin high: standby, bus port enabled and answering.
// [R4] Host waits 2 ms after enable rises before any bus command.
// [R5] Writing one to bit 7 of boost register 0x07 resets logic and configuration.
// [R6] Host waits 2 ms after a software reset before the next command.
// [R7] Flash target per channel: 128 levels from its own flash brightness register.
// [R8] Flash starts on mode bits 11 or strobe rising while strobe pin enabled.
// [R9] Entering flash, current steps through every code up to the target; entered from torch, the code jumps straight to it.
// [R10] Flash started by mode bits: mode bits cleared when the timeout expires.
// [R11] Torch target per channel: 128 levels from its own torch brightness register.
// [R12] Torch starts on mode bits 10 or torch pin high, enabled, not thermistor use.
// [R13] Torch ramps up at a rate chosen by a timing register field.
// [R14] Torch is never ended by flash timeout nor changed by sync input; the code ends a mode-bit torch when a strobe-pin flash over it times out.
// [R15] Mode bits 01 select IR: pass operation, target from flash brightness.
// [R16] In IR the strobe is level only: sources on while high, off while low; with the strobe pin enabled a rise starts a flash whose timeout ends IR.
// [R17] In IR sources switch directly between off and target, no ramp.
// [R18] Output below input: precharge with LEDs off until output reaches 2.2 V.
// [R19] Start in pass operation; boost only when headroom drops below minimum.
// [R20] Bit 2 of 0x07 forces pass-only unless boost already entered; held till standby.
// [R21] During flash, sync high drops to torch current; low restores flash current.
// [R22] Flash timeout clears mode bits and sets bit 0 of flags register 0x0A.
// [R23] Strobe, torch, sync and enable pins pass a two-stage synchroniser first.
// [R24] Ramp moves the code one step per tick and holds once it matches.
package flash_ctrl_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ENABLE = 6'h01;
  localparam logic [5:0] IDX_FLASH1 = 6'h03;
  localparam logic [5:0] IDX_FLASH2 = 6'h04;
  localparam logic [5:0] IDX_TORCH1 = 6'h05;
  localparam logic [5:0] IDX_TORCH2 = 6'h06;
  localparam logic [5:0] IDX_BOOST = 6'h07;
  localparam logic [5:0] IDX_TIMING = 6'h08;
  localparam logic [5:0] IDX_TEMP = 6'h09;
  localparam logic [5:0] IDX_FLAGS1 = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0C;
  // Field positions
  localparam int EN_LED1 = 0;
  localparam int EN_LED2 = 1;
  localparam int EN_MODE_LO = 2;
  localparam int EN_MODE_HI = 3;
  localparam int EN_TORCH_PIN = 4;
  localparam int EN_STROBE_PIN = 5;
  localparam int EN_TX = 7;
  localparam int BC_PASS_ONLY = 2;
  localparam int BC_SW_RESET = 7;
  localparam int TM_TO_LSB = 0;
  localparam int TM_RAMP_LSB = 4;
  localparam int TP_TEMP_SEL = 0;
  localparam int FL1_TIMEOUT = 0;
  // Reset values
  localparam logic [7:0] ENABLE_RST = 8'h80;
  localparam logic [6:0] FLASH_BR_RST = 7'h3F;
  localparam logic [6:0] TORCH_BR_RST = 7'h3F;
  localparam logic [7:0] BOOST_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h1A;
  localparam logic [7:0] TEMP_RST = 8'h00;
  // Mode bit and bus response encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_IR = 2'h1;
  localparam logic [1:0] MODE_TORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchroniser lanes
  localparam int SY_ENABLE_PIN = 0;
  localparam int SY_STROBE = 1;
  localparam int SY_TORCH = 2;
  localparam int SY_TX = 3;
  localparam int SY_VOUT_OK = 4;
  localparam int SY_HR_LOW = 5;
  localparam int SY_VOUT_LOW = 6;
  localparam int SY_N = 7;
  // Timing: flash timeout = base + code * step
  localparam int TO_BASE_MS = 40;
  localparam int TO_STEP_MS = 104;
  localparam int TO_BASE_CYC = TO_BASE_MS * (CLK_HZ / 1000);
  localparam int TO_STEP_CYC = TO_STEP_MS * (CLK_HZ / 1000);
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_TICK_CYC = RAMP_TICK_NS * (CLK_HZ / 1_000_000) / 1000;
  typedef enum logic [1:0] {ST_IDLE, ST_PRECHG, ST_RUN} run_state_e;
endpackage

// *** verilog/flash_mode_ctrl.sv ***
`timescale 1ns/1ps
module flash_mode_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int TO_BASE = TO_BASE_CYC,
  parameter int TO_STEP = TO_STEP_CYC,
  parameter int TICK_CYC = RAMP_TICK_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic hardware_enable_pin, // High standby, low shutdown
  input wire logic strobe_pin, // Flash strobe
  input wire logic torch_pin, // Torch request
  input wire logic tx_pin, // Amplifier sync
  input wire logic vout_ready_pin, // Output reached 2.2 V
  input wire logic headroom_low_pin, // Headroom below minimum
  input wire logic vout_below_vin_pin, // Output below input
  output logic [6:0] led1_code, // Channel 1 current code
  output logic [6:0] led2_code, // Channel 2 current code
  output logic led1_on, // Channel 1 source on
  output logic led2_on, // Channel 2 source on
  output logic flash_scale, // Code uses flash scale
  output logic precharge_en, // Output precharge active
  output logic boost_en // Converter switching
);

  generate
    if (TO_BASE < 1 || TO_STEP < 1 || TO_STEP > 200_000_000 || TO_BASE > 200_000_000)
      $error("flash_mode_ctrl: timeout counts out of range");
    if (TICK_CYC < 1 || TICK_CYC > 511)
      $error("flash_mode_ctrl: ramp tick out of range");
  endgenerate

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [5:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_s;

  typedef struct packed {
    logic [SY_N-1:0] sy1;
    logic [SY_N-1:0] sy2;
    logic strobe_d;
    bus_s bus;
    logic [7:0] enable;
    logic [1:0][6:0] flash_br;
    logic [1:0][6:0] torch_br;
    logic [7:0] boost_cfg;
    logic [7:0] timing;
    logic [7:0] temp;
    logic [7:0] flags1;
    run_state_e st;
    logic pin_flash;
    logic flash_done;
    logic [31:0] to_cnt;
    logic [15:0] tick_cnt;
    logic [1:0][6:0] code;
    logic [1:0] led_on;
    logic flash_scale;
    logic precharge;
    logic boost;
    logic pass_lock;
  } ctl_s;

  localparam ctl_s CTL_RST = '{
    enable: ENABLE_RST,
    flash_br: {FLASH_BR_RST, FLASH_BR_RST},
    torch_br: {TORCH_BR_RST, TORCH_BR_RST},
    boost_cfg: BOOST_RST,
    timing: TIMING_RST,
    temp: TEMP_RST,
    st: ST_IDLE,
    default: '0
  };

  ctl_s st_r;
  ctl_s st_nxt;

  logic [SY_N-1:0] pins;
  logic hw_on;
  logic strobe_lvl;
  logic strobe_rise;
  logic tx_cut;
  logic [1:0] mode;
  logic fl_act;
  logic ir_act;
  logic to_act;
  logic any_act;
  logic run;
  logic cfg_rst;
  logic [31:0] to_lim;
  logic to_expire;
  logic [15:0] tick_lim;
  logic tick_wrap;
  logic scale;
  logic [1:0][6:0] tgt;
  logic [1:0][6:0] step;
  logic [1:0][6:0] ir_code;
  logic [1:0] ir_on;

  assign pins = {vout_below_vin_pin, headroom_low_pin, vout_ready_pin, tx_pin, torch_pin,
                 strobe_pin, hardware_enable_pin};
  assign hw_on = st_r.sy2[SY_ENABLE_PIN];
  assign strobe_lvl = st_r.sy2[SY_STROBE];
  assign strobe_rise = strobe_lvl && !st_r.strobe_d;
  assign tx_cut = st_r.sy2[SY_TX] && st_r.enable[EN_TX];
  assign mode = st_r.enable[EN_MODE_HI:EN_MODE_LO];
  assign cfg_rst = !hw_on || st_r.boost_cfg[BC_SW_RESET]; // [R1] [R5]
  assign fl_act = mode == MODE_FLASH || (st_r.pin_flash && !st_r.flash_done); // [R8]
  assign ir_act = !fl_act && mode == MODE_IR; // [R15]
  // Thermistor use of the torch pin blocks it as a torch request
  assign to_act = !fl_act && !ir_act && (mode == MODE_TORCH ||
                  (st_r.sy2[SY_TORCH] && st_r.enable[EN_TORCH_PIN] &&
                   !st_r.temp[TP_TEMP_SEL])); // [R12]
  assign any_act = fl_act || ir_act || to_act;
  assign run = st_r.st == ST_RUN && any_act;
  assign to_lim = 32'(TO_BASE) + 32'(TO_STEP) * {28'h000_0000, st_r.timing[TM_TO_LSB +: 4]};
  // Only flash and IR count, so torch can never time out
  assign to_expire = (fl_act || ir_act) && st_r.to_cnt == to_lim - 32'd1; // [R14]
  assign tick_lim = to_act ? (16'(TICK_CYC) << st_r.timing[TM_RAMP_LSB +: 3])
                           : 16'(TICK_CYC); // [R13]
  assign tick_wrap = st_r.tick_cnt == tick_lim - 16'd1;
  // Sync input only acts during flash; torch and IR ignore it
  assign scale = (fl_act && !tx_cut) || ir_act; // [R14] [R21]

  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      // Flash and IR share the flash registers, torch has its own
      assign tgt[i] = !st_r.enable[i] ? 7'h00 :
                      scale ? st_r.flash_br[i] : st_r.torch_br[i]; // [R7] [R11] [R15]
      assign step[i] = st_r.code[i] == tgt[i] ? st_r.code[i] :
                       st_r.code[i] < tgt[i] ? st_r.code[i] + 7'h01 :
                       st_r.code[i] - 7'h01; // [R9] [R24]
      assign ir_on[i] = strobe_lvl && st_r.enable[i]; // [R16]
      assign ir_code[i] = strobe_lvl ? tgt[i] : 7'h00; // [R17]
    end
  endgenerate

  always_comb begin
    ctl_s keep;
    logic [7:0] rd;
    keep = st_r;
    rd = 8'h00;
    st_nxt = st_r;
    st_nxt.sy1 = pins; // [R23]
    st_nxt.sy2 = st_r.sy1; // [R23]
    st_nxt.strobe_d = strobe_lvl;

    // Read channel; a flags read clears them before any new event sets
    if (st_r.bus.rvalid && s_axi_rready) st_nxt.bus.rvalid = 1'b0;
    if (st_r.bus.arready && s_axi_arvalid) begin
      st_nxt.bus.rvalid = 1'b1;
      st_nxt.bus.rresp = RESP_OKAY;
      case (s_axi_araddr[ADDR_W-1:2])
        IDX_ENABLE: rd = st_r.enable;
        IDX_FLASH1: rd = {1'b0, st_r.flash_br[0]};
        IDX_FLASH2: rd = {1'b0, st_r.flash_br[1]};
        IDX_TORCH1: rd = {1'b0, st_r.torch_br[0]};
        IDX_TORCH2: rd = {1'b0, st_r.torch_br[1]};
        IDX_BOOST: rd = st_r.boost_cfg;
        IDX_TIMING: rd = st_r.timing;
        IDX_TEMP: rd = st_r.temp;
        IDX_FLAGS1: begin
          rd = st_r.flags1;
          st_nxt.flags1 = 8'h00;
        end
        IDX_STATUS: rd = {2'(st_r.st), st_r.pass_lock, st_r.boost, st_r.precharge,
                          st_r.flash_scale, st_r.led_on};
        default: st_nxt.bus.rresp = RESP_SLVERR;
      endcase
      st_nxt.bus.rdata = 32'(rd);
    end
    st_nxt.bus.arready = !st_nxt.bus.rvalid;

    // Write channel: address and data taken in either order
    if (st_r.bus.bvalid && s_axi_bready) st_nxt.bus.bvalid = 1'b0;
    if (st_r.bus.awready && s_axi_awvalid) begin
      st_nxt.bus.aw_got = 1'b1;
      st_nxt.bus.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (st_r.bus.wready && s_axi_wvalid) begin
      st_nxt.bus.w_got = 1'b1;
      st_nxt.bus.wdata = s_axi_wdata;
      st_nxt.bus.wstrb = s_axi_wstrb;
    end
    if (st_r.bus.aw_got && st_r.bus.w_got) begin
      st_nxt.bus.aw_got = 1'b0;
      st_nxt.bus.w_got = 1'b0;
      st_nxt.bus.bvalid = 1'b1;
      st_nxt.bus.bresp = RESP_OKAY;
      if (st_r.bus.wstrb[0]) begin
        case (st_r.bus.aw_idx)
          IDX_ENABLE: st_nxt.enable = st_r.bus.wdata[7:0];
          IDX_FLASH1: st_nxt.flash_br[0] = st_r.bus.wdata[6:0];
          IDX_FLASH2: st_nxt.flash_br[1] = st_r.bus.wdata[6:0];
          IDX_TORCH1: st_nxt.torch_br[0] = st_r.bus.wdata[6:0];
          IDX_TORCH2: st_nxt.torch_br[1] = st_r.bus.wdata[6:0];
          IDX_BOOST: st_nxt.boost_cfg = st_r.bus.wdata[7:0]; // [R5] [R20]
          IDX_TIMING: st_nxt.timing = st_r.bus.wdata[7:0];
          IDX_TEMP: st_nxt.temp = st_r.bus.wdata[7:0];
          IDX_FLAGS1, IDX_STATUS: ;
          default: st_nxt.bus.bresp = RESP_SLVERR;
        endcase
      end else if (st_r.bus.aw_idx > IDX_STATUS) begin
        st_nxt.bus.bresp = RESP_SLVERR;
      end
    end
    st_nxt.bus.awready = !st_nxt.bus.aw_got && !st_nxt.bus.bvalid;
    st_nxt.bus.wready = !st_nxt.bus.w_got && !st_nxt.bus.bvalid;

    // Pin flash lives while the strobe stays high, or until it times out
    if (strobe_rise && st_r.enable[EN_STROBE_PIN]) st_nxt.pin_flash = 1'b1; // [R8]
    if (!strobe_lvl) begin
      st_nxt.pin_flash = 1'b0;
      st_nxt.flash_done = 1'b0;
    end
    st_nxt.to_cnt = (fl_act || ir_act) ? st_r.to_cnt + 32'd1 : 32'd0;
    if (to_expire) begin
      st_nxt.to_cnt = 32'd0;
      st_nxt.flags1[FL1_TIMEOUT] = 1'b1; // [R22]
      st_nxt.enable[EN_MODE_HI:EN_MODE_LO] = MODE_OFF; // [R10] [R22]
      if (st_r.pin_flash) st_nxt.flash_done = 1'b1;
    end

    unique case (st_r.st)
      ST_IDLE: begin
        if (any_act && st_r.sy2[SY_VOUT_LOW]) begin
          st_nxt.st = ST_PRECHG;
          st_nxt.precharge = 1'b1; // [R18]
        end else if (any_act) begin
          st_nxt.st = ST_RUN;
        end
      end
      ST_PRECHG: begin
        if (!any_act || st_r.sy2[SY_VOUT_OK]) begin
          st_nxt.st = any_act ? ST_RUN : ST_IDLE; // [R18]
          st_nxt.precharge = 1'b0;
        end
      end
      ST_RUN: begin
        if (!any_act) st_nxt.st = ST_IDLE;
      end
    endcase

    st_nxt.flash_scale = scale;
    st_nxt.tick_cnt = 16'h0000;
    if (!run) begin
      st_nxt.code = '0;
      st_nxt.led_on = 2'b00;
    end else if (ir_act) begin
      st_nxt.code = ir_code; // [R16] [R17]
      st_nxt.led_on = ir_on; // [R16]
    end else begin
      st_nxt.led_on = st_r.enable[EN_LED2:EN_LED1];
      st_nxt.tick_cnt = tick_wrap ? 16'h0000 : st_r.tick_cnt + 16'h0001;
      // A scale change under sync jumps straight to the other target
      if (scale != st_r.flash_scale) st_nxt.code = tgt; // [R21]
      else if (tick_wrap) st_nxt.code = step; // [R9] [R13] [R24]
    end

    // Boost is sticky for the whole event; IR always stays in pass
    st_nxt.boost = run && !ir_act &&
                   (st_r.boost || (st_r.sy2[SY_HR_LOW] && !st_r.pass_lock)); // [R15] [R19]
    st_nxt.pass_lock = !st_nxt.boost && st_r.boost_cfg[BC_PASS_ONLY]; // [R20]

    if (cfg_rst) begin
      keep = st_nxt;
      st_nxt = CTL_RST; // [R1] [R5]
      st_nxt.sy1 = keep.sy1;
      st_nxt.sy2 = keep.sy2;
      st_nxt.strobe_d = keep.strobe_d;
      if (hw_on) st_nxt.bus = keep.bus; // [R2] [R3]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= CTL_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.bus.awready;
  assign s_axi_wready = st_r.bus.wready;
  assign s_axi_bresp = st_r.bus.bresp;
  assign s_axi_bvalid = st_r.bus.bvalid;
  assign s_axi_arready = st_r.bus.arready;
  assign s_axi_rdata = st_r.bus.rdata;
  assign s_axi_rresp = st_r.bus.rresp;
  assign s_axi_rvalid = st_r.bus.rvalid;
  assign led1_code = st_r.code[0];
  assign led2_code = st_r.code[1];
  assign led1_on = st_r.led_on[0];
  assign led2_on = st_r.led_on[1];
  assign flash_scale = st_r.flash_scale;
  assign precharge_en = st_r.precharge;
  assign boost_en = st_r.boost;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst || !ce);

  sequence wr_boost_s;
    hw_on && st_r.bus.aw_got && st_r.bus.w_got && st_r.bus.aw_idx == IDX_BOOST &&
      st_r.bus.wstrb[0];
  endsequence
  sequence precharge_start_s;
    st_r.st == ST_IDLE && any_act && st_r.sy2[SY_VOUT_LOW] && !cfg_rst;
  endsequence

  shutdown_regs_a: assert property ( // [R1]
    !hw_on |=> st_r.enable == ENABLE_RST && st_r.st == ST_IDLE && st_r.led_on == 2'b00)
    else $error("shutdown did not restore defaults");
  no_response_a: assert property ( // [R2]
    !hw_on |=> !st_r.bus.awready && !st_r.bus.arready && !st_r.bus.bvalid && !st_r.bus.rvalid)
    else $error("bus answered in shutdown");
  standby_ready_a: assert property ( // [R3]
    hw_on && !st_r.bus.rvalid && !st_r.bus.arready |=> st_r.bus.arready)
    else $error("bus not ready in standby");
  soft_reset_a: assert property ( // [R5]
    wr_boost_s ##0 st_r.bus.wdata[BC_SW_RESET] |-> ##2
      st_r.enable == ENABLE_RST && !st_r.boost_cfg[BC_SW_RESET])
    else $error("software reset did not clear registers");
  timeout_clear_a: assert property ( // [R10]
    to_expire && !cfg_rst && !(st_r.bus.aw_got && st_r.bus.w_got) |=>
      st_r.flags1[FL1_TIMEOUT] && st_r.enable[EN_MODE_HI:EN_MODE_LO] == MODE_OFF)
    else $error("timeout did not clear mode or set flag");
  ramp_step_a: assert property ( // [R9]
    st_r.st == ST_RUN && $past(st_r.st) == ST_RUN && !$past(ir_act) && !$past(cfg_rst) &&
      $past(any_act) && st_r.flash_scale == $past(st_r.flash_scale) |->
      st_r.code[0] == $past(st_r.code[0]) || st_r.code[0] == $past(st_r.code[0]) + 7'h01 ||
      st_r.code[0] + 7'h01 == $past(st_r.code[0]))
    else $error("ramp skipped a code");
  ir_direct_a: assert property ( // [R17]
    run && ir_act && strobe_lvl && st_r.enable[EN_LED1] && !cfg_rst |=>
      st_r.led_on[0] && st_r.code[0] == $past(st_r.flash_br[0]))
    else $error("IR source not at target at once");
  precharge_off_a: assert property ( // [R18]
    precharge_start_s |=> st_r.precharge && st_r.led_on == 2'b00)
    else $error("LEDs on during precharge");
  pass_lock_a: assert property ( // [R20]
    st_r.pass_lock |=> !st_r.boost)
    else $error("boost while pass-only forced");
  boost_hold_a: assert property ( // [R19]
    st_r.boost && run && !cfg_rst |=> st_r.boost)
    else $error("boost dropped during event");
  tx_torch_a: assert property ( // [R21]
    run && fl_act && tx_cut && st_r.flash_scale && !cfg_rst |=>
      !st_r.flash_scale && st_r.code[0] == $past(tgt[0]))
    else $error("sync did not drop to torch");

endmodule // flash_mode_ctrl

// *** bench/analog_front.sv ***
`timescale 1ns/1ps
module analog_front #(
  parameter int CHARGE_CYC = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset
  input wire logic precharge_en, // Precharge current on
  output logic vout_ready_pin, // Output reached 2.2 V
  output logic vout_below_vin_pin // Output below input
);
  int cnt;
  // The cap only charges while precharge runs; it holds its charge afterwards
  always @(posedge clk_sys) begin
    if (!nrst)
      cnt <= 0;
    else if (precharge_en && cnt < CHARGE_CYC)
      cnt <= cnt + 1;
  end
  assign vout_ready_pin = (cnt == CHARGE_CYC);
  assign vout_below_vin_pin = !vout_ready_pin;
endmodule // analog_front

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  import flash_ctrl_pkg::*;
  // The design has no lockout of its own, so a short host wait keeps the run brief
  localparam int HOST_WAIT = 200;
  int errors = 0;
  int n_checks = 0;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic hw_enable = 1'b1, ce = 1'b1, strobe = 1'b0, torch = 1'b0, tx = 1'b0, hr_low = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, led1_on, led2_on, fscale, prechg, boost;
  logic vready, vbelow;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] code1, code2;

  always #12.5 clk_sys = ~clk_sys;

  flash_mode_ctrl #(.TO_BASE(20), .TO_STEP(10), .TICK_CYC(2)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hardware_enable_pin(hw_enable), .strobe_pin(strobe), .torch_pin(torch), .tx_pin(tx),
    .vout_ready_pin(vready), .headroom_low_pin(hr_low), .vout_below_vin_pin(vbelow),
    .led1_code(code1), .led2_code(code2), .led1_on(led1_on), .led2_on(led2_on),
    .flash_scale(fscale), .precharge_en(prechg), .boost_en(boost)
  );

  analog_front #(.CHARGE_CYC(8)) far (.clk_sys(clk_sys), .nrst(nrst),
    .precharge_en(prechg), .vout_ready_pin(vready), .vout_below_vin_pin(vbelow));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up;
    errors++;
    $display("unexpected at %0t: no answer in time", $time);
    complete_run;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] strb);
    int n;
    bit aw_ok;
    bit w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 400) give_up;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(RESP_OKAY));
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
      if (n > 400) give_up;
    end while (rvalid !== 1'b1);
    chk(rdata, {24'h00_0000, exp});
    chk(32'(rresp), 32'(resp));
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Shutdown must leave a read unanswered, so this one gives up on purpose
  task automatic rd_none(input logic [5:0] idx);
    bit seen;
    seen = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(posedge clk_sys);
      if (arready === 1'b1 || rvalid === 1'b1) seen = 1;
    end
    chk(32'(seen), 32'h0000_0000);
    arvalid <= 1'b0;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_code(input logic [6:0] c);
    int n;
    n = 0;
    while (code1 !== c) begin
      @(posedge clk_sys);
      n++;
      if (n > 600) give_up;
    end
    n_checks++;
  endtask

  task automatic wait_val(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(posedge clk_sys);
      n++;
      if (n > 600) give_up;
    end
    n_checks++;
  endtask

  task automatic complete_run;
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (HOST_WAIT) @(posedge clk_sys);
    rd(IDX_ENABLE, 8'h80, RESP_OKAY);
    rd(IDX_FLASH1, 8'h3F, RESP_OKAY);
    rd(IDX_TIMING, 8'h1A, RESP_OKAY);
    rd(6'h3F, 8'h00, RESP_SLVERR);
    wr(IDX_TORCH2, 8'h11, 4'h0);
    rd(IDX_TORCH2, 8'h3F, RESP_OKAY);
    wr(IDX_FLASH1, 8'h04, 4'h1);
    wr(IDX_TORCH1, 8'h03, 4'h1);
    wr(IDX_ENABLE, 8'h89, 4'h1);
    wait_val(prechg, 1'b1);
    chk(32'(led1_on), 32'h0000_0000);
    for (int k = 1; k <= 3; k++) wait_code(k[6:0]);
    chk(32'(fscale), 32'h0000_0000);
    chk(32'(code2), 32'h0000_0000);
    chk(32'(led2_on), 32'h0000_0000);
    tx <= 1'b1;
    // Longer than the 120-cycle flash timeout set by the parameters
    repeat (150) @(posedge clk_sys);
    chk(32'(code1), 32'h0000_0003);
    chk(32'(boost), 32'h0000_0000);
    tx <= 1'b0;
    hr_low <= 1'b1;
    wait_val(boost, 1'b1);
    wr(IDX_ENABLE, 8'h81, 4'h1);
    wait_val(led1_on, 1'b0);
    hr_low <= 1'b0;
    wr(IDX_ENABLE, 8'h8D, 4'h1);
    for (int k = 1; k <= 4; k++) wait_code(k[6:0]);
    chk(32'(fscale), 32'h0000_0001);
    tx <= 1'b1;
    wait_code(7'h03);
    chk(32'(fscale), 32'h0000_0000);
    tx <= 1'b0;
    wait_code(7'h04);
    wait_val(led1_on, 1'b0);
    rd(IDX_ENABLE, 8'h81, RESP_OKAY);
    rd(IDX_FLAGS1, 8'h01, RESP_OKAY);
    rd(IDX_FLAGS1, 8'h00, RESP_OKAY);
    wr(IDX_ENABLE, 8'hA1, 4'h1);
    strobe <= 1'b1;
    for (int k = 1; k <= 4; k++) wait_code(k[6:0]);
    strobe <= 1'b0;
    wait_val(led1_on, 1'b0);
    wr(IDX_TEMP, 8'h01, 4'h1);
    wr(IDX_ENABLE, 8'h91, 4'h1);
    torch <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(32'(led1_on), 32'h0000_0000);
    wr(IDX_TEMP, 8'h00, 4'h1);
    wait_code(7'h03);
    // A frozen block must not see the pin fall
    ce <= 1'b0;
    torch <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk(32'(led1_on), 32'h0000_0001);
    ce <= 1'b1;
    wait_val(led1_on, 1'b0);
    wr(IDX_ENABLE, 8'h87, 4'h1);
    hr_low <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(32'(led1_on), 32'h0000_0000);
    strobe <= 1'b1;
    wait_val(led1_on, 1'b1);
    chk(32'(code1), 32'h0000_0004);
    chk(32'(led2_on), 32'h0000_0001);
    chk(32'(code2), 32'h0000_003F);
    chk(32'(boost), 32'h0000_0000);
    strobe <= 1'b0;
    wait_val(led1_on, 1'b0);
    chk(32'(code1), 32'h0000_0000);
    chk(32'(led2_on), 32'h0000_0000);
    wr(IDX_ENABLE, 8'h81, 4'h1);
    wr(IDX_BOOST, 8'h04, 4'h1);
    wr(IDX_ENABLE, 8'h89, 4'h1);
    wait_code(7'h03);
    repeat (50) @(posedge clk_sys);
    chk(32'(boost), 32'h0000_0000);
    rd(IDX_STATUS, 8'hA1, RESP_OKAY);
    wr(IDX_BOOST, 8'h80, 4'h1);
    repeat (HOST_WAIT) @(posedge clk_sys);
    chk(32'(led1_on), 32'h0000_0000);
    rd(IDX_ENABLE, 8'h80, RESP_OKAY);
    rd(IDX_BOOST, 8'h00, RESP_OKAY);
    rd(IDX_TORCH1, 8'h3F, RESP_OKAY);
    rd(IDX_STATUS, 8'h00, RESP_OKAY);
    hr_low <= 1'b0;
    wr(IDX_FLASH1, 8'h10, 4'h1);
    hw_enable <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd_none(IDX_FLASH1);
    hw_enable <= 1'b1;
    repeat (HOST_WAIT) @(posedge clk_sys);
    rd(IDX_FLASH1, 8'h3F, RESP_OKAY);
    complete_run;
  end
endmodule // tb
